// ### verilog/ccc_top.sv
`timescale 1ns/10ps
module ccc_top
  import ccc_pkg::*;
#(
  parameter int unsigned INT_CYC     = INT_PULSE_CYC,
  parameter int unsigned CONV_PERIOD = CONV_PERIOD_CYC,
  parameter int unsigned CONV_TIME   = CONV_TIME_CYC,
  parameter int unsigned BLINK_HALF  = BLINK_HALF_CYC,
  parameter int unsigned SEC_TICK    = SEC_TICK_CYC
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // Pins and analog front end
  input  wire logic        i_charge_enable_n,
  input  wire logic        i_wake_button_pin_n,
  input  ccc_sense_s       i_sense,
  input  ccc_adc_s         i_adc,
  // Outputs to power stage and host
  output logic             o_int_n,
  output logic             o_stat_out,
  output logic             o_stat_oe,
  output logic             o_charge_on,
  output logic [1:0]       o_cur_sel,
  output logic [6:0]       o_fast_charge_current_setting,
  output logic [3:0]       o_precharge_current,
  output logic             o_recharge_threshold_select,
  output logic [1:0]       o_boost_hot_threshold_select,
  output logic             o_boost_cold_threshold_select,
  output logic             o_boost_en,
  output logic             o_battery_switch_on,
  output logic [8:0]       o_vreg_target,
  output logic             o_conv_active
);

  function automatic ccc_reg_e ccc_decode(input logic [31:0] a);
    ccc_reg_e r;
    r = REG_NONE;
    if (a[31:8] == 24'h0) begin
      case (a[7:0])
        ADDR_CTRL:   r = REG_CTRL;
        ADDR_CHGCFG: r = REG_CHGCFG;
        ADDR_COMP:   r = REG_COMP;
        ADDR_STATUS: r = REG_STATUS;
        ADDR_FAULT:  r = REG_FAULT;
        ADDR_MON0:   r = REG_MON0;
        ADDR_MON1:   r = REG_MON1;
        ADDR_VREG:   r = REG_VREG;
        default:     r = REG_NONE;
      endcase
    end
    return r;
  endfunction : ccc_decode

  function automatic logic [16:0] ccc_timer_limit(input logic [1:0] sel);
    int unsigned h;
    case (sel)
      2'h0:    h = FAST_TIMER_H0;
      2'h1:    h = FAST_TIMER_H1;
      2'h2:    h = FAST_TIMER_H2;
      default: h = FAST_TIMER_H3;
    endcase
    return 17'(h * SEC_PER_HOUR);
  endfunction : ccc_timer_limit

  localparam logic [16:0] LOWBAT_SEC = 17'(LOWBAT_TIMER_H * SEC_PER_HOUR);

  // Two-flop synchronisers for everything arriving from pins
  ccc_sense_s sense_m, sense;
  ccc_adc_s   adc_m, adc;
  logic       ce_n_m, ce_n, wake_m, wake, wake_d;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sense_m <= '0;
      sense   <= '0;
      adc_m   <= '0;
      adc     <= '0;
      ce_n_m  <= 1'b1;
      ce_n    <= 1'b1;
      wake_m  <= 1'b1;
      wake    <= 1'b1;
      wake_d  <= 1'b1;
    end else begin
      sense_m <= i_sense;
      sense   <= sense_m;
      adc_m   <= i_adc;
      adc     <= adc_m;
      ce_n_m  <= i_charge_enable_n;
      ce_n    <= ce_n_m;
      wake_m  <= i_wake_button_pin_n;
      wake    <= wake_m;
      wake_d  <= wake;
    end
  end

  // Bus and register state
  logic        wr_q, next_wr_q;
  logic [31:0] addr_q, next_addr_q;
  logic [31:0] hrdata, next_hrdata;
  logic [31:0] ctrl, next_ctrl, chgcfg, next_chgcfg, comp, next_comp;
  logic        sw_off, next_sw_off;
  logic [6:0]  fault, next_fault;
  // Charge state
  ccc_chg_e    state, next_state;
  logic [31:0] sec_cnt, next_sec_cnt;
  logic [16:0] tmr_sec, next_tmr_sec;
  logic        half_ph, next_half_ph;
  logic        tmr_fault, next_tmr_fault;
  // Monitor state
  ccc_mon_e    mon, next_mon;
  logic [31:0] mon_cnt, next_mon_cnt;
  ccc_adc_s    mon_res, next_mon_res;
  // Interrupt and status pin
  logic        pend, next_pend, int_n, next_int_n;
  logic [31:0] int_cnt, next_int_cnt, blink_cnt, next_blink_cnt;
  logic        blink, next_blink;
  logic [8:0]  vreg, next_vreg;

  logic        addr_ph, enable, start_ok, ts_bad, ts_ok, slow, tick, advance, expire;
  logic        term_evt, ts_evt, bst_evt, trig_req, conv_end, rd_fault;
  ccc_reg_e    widx;
  logic [1:0]  phase;
  logic [15:0] prod;
  logic [7:0]  comp_add;

  assign addr_ph  = i_hsel & i_hready & i_htrans[1];
  assign widx     = ccc_decode(addr_q);
  assign enable   = ctrl[CTRL_CHG_EN] & ~ce_n;
  assign ts_ok    = ~sense.ts_cold & ~sense.ts_warm;
  assign ts_bad   = sense.ts_cold | sense.ts_hot;
  assign start_ok = sense.conv_on & enable & ts_ok & ~tmr_fault & ~sw_off
                  & (chgcfg[CHG_FAST_CHARGE_CURRENT_SETTING_LSB +: 7] != 7'h0);
  assign trig_req = wr_q & (widx == REG_CTRL) & i_hwdata[CTRL_TRIG]
                  & ~ctrl[CTRL_CONT];
  assign rd_fault = addr_ph & ~i_hwrite & (ccc_decode(i_haddr) == REG_FAULT);
  assign bst_evt  = sense.boost_req & ~sw_off & sense.ts_boost_out
                  & (ctrl[CTRL_BOOST_HOT_THRESHOLD_SELECT_LSB +: 2] != BOOST_HOT_THRESHOLD_SELECT_OFF);

  always_comb begin
    case (state)
      CHG_PRE:  phase = 2'h1;
      CHG_FAST: phase = 2'h2;
      CHG_DONE: phase = 2'h3;
      CHG_SUSP: phase = sense.vbat_pre ? 2'h1 : 2'h2;
      default:  phase = 2'h0;
    endcase
  end

  // Bus: zero wait state, read data captured in the address phase
  always_comb begin
    next_wr_q   = addr_ph & i_hwrite;
    next_addr_q = addr_ph ? i_haddr : addr_q;
    next_hrdata = hrdata;
    if (addr_ph & ~i_hwrite) begin
      case (ccc_decode(i_haddr))
        REG_CTRL: begin
          next_hrdata = ctrl;
          next_hrdata[CTRL_TRIG]   = (mon != MON_IDLE);
          next_hrdata[CTRL_SW_OFF] = sw_off;
        end
        REG_CHGCFG: next_hrdata = chgcfg;
        REG_COMP:   next_hrdata = comp;
        REG_STATUS: next_hrdata = {28'h0, o_boost_en, tmr_fault, phase};
        REG_FAULT:  next_hrdata = {25'h0, fault};
        REG_MON0:   next_hrdata = {adc_field(mon_res)};
        REG_MON1:   next_hrdata = {24'h0, mon_res.ibat};
        REG_VREG:   next_hrdata = {23'h0, vreg};
        default:    next_hrdata = 32'h0;
      endcase
    end
    next_ctrl   = ctrl;
    next_chgcfg = chgcfg;
    next_comp   = comp;
    next_sw_off = sw_off;
    if (wr_q) begin
      case (widx)
        REG_CTRL: begin
          next_ctrl   = i_hwdata & CTRL_WMASK;
          next_sw_off = i_hwdata[CTRL_SW_OFF];
        end
        REG_CHGCFG: next_chgcfg = i_hwdata & CHGCFG_WMASK;
        REG_COMP:   next_comp   = i_hwdata & COMP_WMASK;
        default:    next_ctrl   = ctrl;
      endcase
    end
    if (wake & ~wake_d) next_sw_off = 1'b0;
    if (bst_evt) next_sw_off = 1'b1;
  end

  function automatic logic [31:0] adc_field(input ccc_adc_s r);
    return {r.vbus, r.ts, r.vsys, r.vbat};
  endfunction : adc_field

  // Safety timer, half rate under regulation
  assign slow    = ctrl[CTRL_SLOW_EN] & (sense.dynamic_power_limit | sense.thermal);
  assign tick    = (sec_cnt == 32'(SEC_TICK - 1));
  assign advance = tick & (~slow | half_ph);
  assign expire  = ctrl[CTRL_TMR_EN] & advance & enable & sense.conv_on
                 & ((state == CHG_PRE) | (state == CHG_FAST))
                 & ((tmr_sec + 17'h1) >= (sense.vbat_lowv ? LOWBAT_SEC
                    : ccc_timer_limit(chgcfg[CHG_TMR_LSB +: 2])));
  assign term_evt = (state == CHG_FAST) & ~ts_bad & ~expire & ctrl[CTRL_TERM_EN]
                  & sense.below_term & sense.above_rechg & enable & sense.conv_on
                  & ~sense.dynamic_power_limit & ~sense.thermal;
  assign ts_evt   = ((state == CHG_PRE) | (state == CHG_FAST)) & ts_bad
                  & enable & sense.conv_on;

  always_comb begin
    next_state     = state;
    next_tmr_fault = tmr_fault;
    next_sec_cnt   = tick ? 32'h0 : sec_cnt + 32'h1;
    next_half_ph   = (tick & slow) ? ~half_ph : half_ph;
    next_tmr_sec   = advance ? tmr_sec + 17'h1 : tmr_sec;
    if (~enable | ~sense.conv_on) begin
      next_state     = CHG_OFF;
      next_tmr_fault = 1'b0;
    end else begin
      case (state)
        CHG_OFF, CHG_DONE: begin
          if (start_ok & ((state == CHG_OFF) | ~sense.above_rechg)) begin
            next_state   = sense.vbat_pre ? CHG_PRE : CHG_FAST;
            next_sec_cnt = 32'h0;
            next_tmr_sec = 17'h0;
            next_half_ph = 1'b0;
          end
        end
        CHG_PRE, CHG_FAST: begin
          if (ts_bad) begin
            next_state = CHG_SUSP;
          end else if (expire) begin
            next_state     = CHG_SUSP;
            next_tmr_fault = 1'b1;
          end else if (term_evt) begin
            next_state = CHG_DONE;
          end else if ((state == CHG_PRE) & ~sense.vbat_pre) begin
            next_state = CHG_FAST;
          end
        end
        CHG_SUSP: begin
          if (ts_ok & ~tmr_fault) begin
            next_state = sense.vbat_pre ? CHG_PRE : CHG_FAST;
          end
        end
        default: next_state = CHG_OFF;
      endcase
    end
    // Read clears the record; a new event in the same cycle still lands
    next_fault = rd_fault ? 7'h0 : fault;
    if (ts_evt) next_fault[2:0] = {sense.ts_hot, sense.ts_warm, sense.ts_cold};
    if (expire) next_fault[FLT_CHG_LSB +: 2] = TMR_FAULT;
    if (bst_evt) next_fault[FLT_BOOST] = 1'b1;
  end

  // Battery monitor sequencing
  assign conv_end = (mon == MON_CONV) & (mon_cnt == 32'(CONV_TIME - 1));

  always_comb begin
    next_mon     = mon;
    next_mon_cnt = mon_cnt + 32'h1;
    next_mon_res = mon_res;
    case (mon)
      MON_IDLE: begin
        next_mon_cnt = 32'h0;
        if (ctrl[CTRL_CONT] | trig_req) next_mon = MON_CONV;
      end
      MON_CONV: begin
        if (conv_end) begin
          next_mon_res = adc;
          next_mon     = ctrl[CTRL_CONT] ? MON_WAIT : MON_IDLE;
        end
      end
      MON_WAIT: begin
        if (~ctrl[CTRL_CONT]) begin
          next_mon = MON_IDLE;
        end else if (mon_cnt == 32'(CONV_PERIOD - 1)) begin
          next_mon     = MON_CONV;
          next_mon_cnt = 32'h0;
        end
      end
      default: next_mon = MON_IDLE;
    endcase
  end

  // Interrupt pulse, status pin and compensation target
  always_comb begin
    next_pend      = pend;
    next_int_n     = int_n;
    next_int_cnt   = int_cnt;
    if (~int_n) begin
      next_int_cnt = int_cnt + 32'h1;
      if (int_cnt == 32'(INT_CYC - 1)) next_int_n = 1'b1;
    end else if (pend) begin
      next_int_n   = 1'b0;
      next_int_cnt = 32'h0;
      next_pend    = 1'b0;
    end
    if (term_evt | ts_evt | expire | bst_evt) next_pend = 1'b1;
    next_blink     = blink;
    next_blink_cnt = blink_cnt + 32'h1;
    if (blink_cnt == 32'(BLINK_HALF - 1)) begin
      next_blink_cnt = 32'h0;
      next_blink     = ~blink;
    end
    prod      = 16'(mon_res.ibat * comp[COMP_RES_LSB +: 8]);
    comp_add  = (prod > {8'h0, comp[COMP_CLAMP_LSB +: 8]}) ? comp[COMP_CLAMP_LSB +: 8]
              : prod[7:0];
    next_vreg = {1'b0, comp[COMP_BASE_LSB +: 8]} + {1'b0, comp_add};
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_q      <= 1'b0;
      addr_q    <= 32'h0;
      hrdata    <= 32'h0;
      ctrl      <= CTRL_RST;
      chgcfg    <= CHGCFG_RST;
      comp      <= COMP_RST;
      sw_off    <= 1'b0;
      fault     <= 7'h0;
      state     <= CHG_OFF;
      sec_cnt   <= 32'h0;
      tmr_sec   <= 17'h0;
      half_ph   <= 1'b0;
      tmr_fault <= 1'b0;
      mon       <= MON_IDLE;
      mon_cnt   <= 32'h0;
      mon_res   <= '0;
      pend      <= 1'b0;
      int_n     <= 1'b1;
      int_cnt   <= 32'h0;
      blink_cnt <= 32'h0;
      blink     <= 1'b0;
      vreg      <= 9'h0;
    end else begin
      wr_q      <= next_wr_q;
      addr_q    <= next_addr_q;
      hrdata    <= next_hrdata;
      ctrl      <= next_ctrl;
      chgcfg    <= next_chgcfg;
      comp      <= next_comp;
      sw_off    <= next_sw_off;
      fault     <= next_fault;
      state     <= next_state;
      sec_cnt   <= next_sec_cnt;
      tmr_sec   <= next_tmr_sec;
      half_ph   <= next_half_ph;
      tmr_fault <= next_tmr_fault;
      mon       <= next_mon;
      mon_cnt   <= next_mon_cnt;
      mon_res   <= next_mon_res;
      pend      <= next_pend;
      int_n     <= next_int_n;
      int_cnt   <= next_int_cnt;
      blink_cnt <= next_blink_cnt;
      blink     <= next_blink;
      vreg      <= next_vreg;
    end
  end

  // Registered pin-facing outputs
  logic stat_oe, chg_on, bst_en, sw_on;
  logic [1:0] cur_sel;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      stat_oe <= 1'b0;
      chg_on  <= 1'b0;
      bst_en  <= 1'b0;
      sw_on   <= 1'b1;
      cur_sel <= CUR_SHORT;
    end else begin
      if (ctrl[CTRL_STATUS_PIN_DISABLE]) begin
        stat_oe <= 1'b0;
      end else if ((state == CHG_SUSP) | (sense.boost_req & sw_off)) begin
        stat_oe <= blink;
      end else begin
        stat_oe <= (state == CHG_PRE) | (state == CHG_FAST);
      end
      chg_on  <= (state == CHG_PRE) | (state == CHG_FAST);
      bst_en  <= sense.boost_req & ~sw_off & ~bst_evt;
      sw_on   <= ~sw_off & ((state != CHG_DONE) | sense.supplement_req);
      cur_sel <= sense.vbat_short ? CUR_SHORT
               : (sense.vbat_pre ? CUR_PRE : CUR_FAST);
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata;
  assign o_int_n     = int_n;
  assign o_stat_out  = 1'b0;
  assign o_stat_oe   = stat_oe;
  assign o_charge_on = chg_on;
  assign o_cur_sel   = cur_sel;
  assign o_fast_charge_current_setting = chgcfg[CHG_FAST_CHARGE_CURRENT_SETTING_LSB +: 7];
  assign o_precharge_current           = chgcfg[CHG_IPRE_LSB +: 4];
  assign o_recharge_threshold_select   = chgcfg[CHG_RECHG];
  assign o_boost_hot_threshold_select  = ctrl[CTRL_BOOST_HOT_THRESHOLD_SELECT_LSB +: 2];
  assign o_boost_cold_threshold_select = ctrl[CTRL_BOOST_COLD_THRESHOLD_SELECT];
  assign o_boost_en          = bst_en;
  assign o_battery_switch_on = sw_on;
  assign o_vreg_target       = vreg;
  assign o_conv_active       = (mon == MON_CONV);

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  logic [31:0] low_cnt;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) low_cnt <= 32'h0;
    else low_cnt <= o_int_n ? 32'h0 : low_cnt + 32'h1;
  end

  sequence s_idle_then_charge;
    (state == CHG_OFF) ##1 ((state == CHG_PRE) || (state == CHG_FAST));
  endsequence

  term_to_done_a: assert property (term_evt |=> (state == CHG_DONE) && (phase == 2'h3))
    else $error("termination did not reach done");
  term_blocked_a: assert property ((state == CHG_FAST) && !ctrl[CTRL_TERM_EN]
                    |=> state != CHG_DONE)
    else $error("terminated with termination disabled");
  start_guard_a: assert property (s_idle_then_charge |-> $past(start_ok))
    else $error("cycle started without start conditions");
  int_width_a: assert property ($rose(o_int_n) |-> low_cnt == 32'(INT_CYC))
    else $error("interrupt pulse has wrong width");
  stat_charge_a: assert property (((state == CHG_FAST) && !ctrl[CTRL_STATUS_PIN_DISABLE])
                   ##1 (state == CHG_FAST) |-> o_stat_oe && !o_stat_out)
    else $error("status pin not low while charging");
  boost_fault_a: assert property (bst_evt |=> sw_off ##1 !o_boost_en)
    else $error("boost thermistor fault not handled");
  timer_fault_a: assert property (expire |=> fault[FLT_CHG_LSB +: 2] == TMR_FAULT
                   ##[1:3] !o_int_n)
    else $error("timer expiry not reported");
  mon_whole_a: assert property (!$stable(mon_res) |-> $past(conv_end))
    else $error("monitor result changed outside conversion end");
  suspend_ts_a: assert property (ts_evt |=> state == CHG_SUSP)
    else $error("thermistor fault did not suspend");

endmodule : ccc_top

// ### verilog/ccc_pkg.sv
package ccc_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned INT_PULSE_NS    = 256_000;
  localparam int unsigned INT_PULSE_CYC   = INT_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_PERIOD_MS  = 1000;
  localparam int unsigned CONV_PERIOD_CYC = CONV_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV_TIME_MS    = 50;
  localparam int unsigned CONV_TIME_CYC   = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_HALF_MS   = 500;
  localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned SEC_TICK_CYC    = CLK_HZ;
  localparam int unsigned SEC_PER_HOUR    = 3600;
  localparam int unsigned LOWBAT_TIMER_H  = 4;
  localparam int unsigned FAST_TIMER_H0   = 4;
  localparam int unsigned FAST_TIMER_H1   = 8;
  localparam int unsigned FAST_TIMER_H2   = 12;
  localparam int unsigned FAST_TIMER_H3   = 16;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CHGCFG = 8'h04;
  localparam logic [7:0] ADDR_COMP   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_FAULT  = 8'h10;
  localparam logic [7:0] ADDR_MON0   = 8'h14;
  localparam logic [7:0] ADDR_MON1   = 8'h18;
  localparam logic [7:0] ADDR_VREG   = 8'h1c;

  // Control fields
  localparam int CTRL_CHG_EN   = 0;
  localparam int CTRL_TERM_EN  = 1;
  localparam int CTRL_TMR_EN   = 2;
  localparam int CTRL_SLOW_EN  = 3;
  localparam int CTRL_STATUS_PIN_DISABLE = 4;
  localparam int CTRL_CONT     = 5;
  localparam int CTRL_TRIG     = 6;
  localparam int CTRL_SW_OFF   = 7;
  localparam int CTRL_BOOST_HOT_THRESHOLD_SELECT_LSB = 8;
  localparam int CTRL_BOOST_COLD_THRESHOLD_SELECT    = 10;
  localparam logic [31:0] CTRL_RST   = 32'h0000_000f;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_073f;
  // Charge configuration fields
  localparam int CHG_FAST_CHARGE_CURRENT_SETTING_LSB  = 0;
  localparam int CHG_IPRE_LSB  = 8;
  localparam int CHG_TMR_LSB   = 16;
  localparam int CHG_RECHG     = 18;
  localparam logic [31:0] CHGCFG_RST   = 32'h0002_0120;
  localparam logic [31:0] CHGCFG_WMASK = 32'h0007_0f7f;
  // Compensation fields: base, resistance, clamp
  localparam int COMP_BASE_LSB  = 0;
  localparam int COMP_RES_LSB   = 8;
  localparam int COMP_CLAMP_LSB = 16;
  localparam logic [31:0] COMP_RST   = 32'h0000_0080;
  localparam logic [31:0] COMP_WMASK = 32'h00ff_ffff;
  // Fault fields
  localparam int FLT_CHG_LSB = 4;
  localparam int FLT_BOOST   = 6;

  localparam logic [1:0] CUR_SHORT = 2'h0;
  localparam logic [1:0] CUR_PRE   = 2'h1;
  localparam logic [1:0] CUR_FAST  = 2'h2;
  localparam logic [1:0] BOOST_HOT_THRESHOLD_SELECT_OFF  = 2'h3;
  localparam logic [1:0] TMR_FAULT = 2'h3;

  typedef enum logic [2:0] {
    CHG_OFF  = 3'h0,
    CHG_PRE  = 3'h1,
    CHG_FAST = 3'h3,
    CHG_DONE = 3'h2,
    CHG_SUSP = 3'h6
  } ccc_chg_e;

  typedef enum logic [1:0] {
    MON_IDLE = 2'h0,
    MON_CONV = 2'h1,
    MON_WAIT = 2'h3
  } ccc_mon_e;

  typedef enum logic [3:0] {
    REG_CTRL, REG_CHGCFG, REG_COMP, REG_STATUS,
    REG_FAULT, REG_MON0, REG_MON1, REG_VREG, REG_NONE
  } ccc_reg_e;

  typedef struct packed {
    logic conv_on;
    logic vbat_short;
    logic vbat_pre;
    logic vbat_lowv;
    logic above_rechg;
    logic below_term;
    logic dynamic_power_limit;
    logic thermal;
    logic ts_cold;
    logic ts_warm;
    logic ts_hot;
    logic ts_boost_out;
    logic boost_req;
    logic supplement_req;
  } ccc_sense_s;

  typedef struct packed {
    logic [7:0] ibat;
    logic [7:0] vbus;
    logic [7:0] ts;
    logic [7:0] vsys;
    logic [7:0] vbat;
  } ccc_adc_s;

endpackage : ccc_pkg

// ### sim/ccc_batt_model.sv
`timescale 1ns/10ps
module ccc_batt_model
  import ccc_pkg::*;
(
  // Battery state commanded by the bench
  input  wire logic [1:0]  i_lvl,
  input  wire logic        i_full,
  input  wire logic        i_dpm,
  input  wire logic [39:0] i_raw,
  // Thermistor flags {cold, warm, hot}, boost window and boost request
  input  wire logic [2:0]  i_ts,
  input  wire logic        i_bts,
  input  wire logic        i_boost,
  // Sensed levels and converter results
  output ccc_sense_s       o_sense,
  output ccc_adc_s         o_adc
);
  // Level 0 below 2 V, 1 below 3 V, 2 above; a full cell is above recharge with low current
  assign o_sense = {1'b1, i_lvl == 2'h0, i_lvl < 2'h2, i_lvl < 2'h2, i_full, i_full, i_dpm, 1'b0,
                    i_ts, i_bts, i_boost, 1'b0};
  assign o_adc   = i_raw;
endmodule : ccc_batt_model

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import ccc_pkg::*;
;
  logic        clk, rst, hsel, hwrite, ce_n, wake_n, full, dynamic_power_limit, rdy, int_n, oe, bsw, conv;
  logic        bts, boost, chg, ben, hresp, sout, rechg, boost_cold_threshold_select;
  logic [1:0]  htrans, lvl, cur, boost_hot_threshold_select;
  logic [2:0]  ts, hsize;
  logic [3:0]  pre;
  logic [6:0]  fcs;
  logic [31:0] haddr, hwdata, hrdata, rd, st;
  logic [39:0] raw;
  logic [8:0]  vreg;
  ccc_sense_s  sense;
  ccc_adc_s    adc;
  int          failures, check_count, n;
  logic [31:0] seed = 32'hd960aa7c;

  ccc_batt_model i_bat (.i_lvl(lvl), .i_full(full), .i_dpm(dynamic_power_limit), .i_raw(raw), .i_ts(ts),
    .i_bts(bts), .i_boost(boost), .o_sense(sense), .o_adc(adc));
  // Short counts keep the run brief; expectations use the same figures
  ccc_top #(.INT_CYC(8), .CONV_PERIOD(100), .CONV_TIME(10), .BLINK_HALF(4), .SEC_TICK(4)) i_dut (
    .i_clk_sys(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_charge_enable_n(ce_n), .i_wake_button_pin_n(wake_n),
    .i_sense(sense), .i_adc(adc), .o_int_n(int_n), .o_stat_out(sout), .o_stat_oe(oe),
    .o_charge_on(chg), .o_cur_sel(cur), .o_fast_charge_current_setting(fcs),
    .o_precharge_current(pre), .o_recharge_threshold_select(rechg),
    .o_boost_hot_threshold_select(boost_hot_threshold_select), .o_boost_cold_threshold_select(boost_cold_threshold_select),
    .o_boost_en(ben), .o_battery_switch_on(bsw), .o_vreg_target(vreg), .o_conv_active(conv));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [8:0] exp_vreg(logic [31:0] c, logic [7:0] ib);
    logic [15:0] p;
    p = ib * c[15:8];
    return {1'b0, c[7:0]} + ((p < {8'h0, c[23:16]}) ? p[8:0] : {1'b0, c[23:16]});
  endfunction : exp_vreg

  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a}; hsize <= 3'h2;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task give_verdict();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  initial begin
    rst = 1; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0; ce_n = 0; wake_n = 1;
    lvl = 2; full = 0; dynamic_power_limit = 0; raw = 0; ts = 0; bts = 0; boost = 0; hsize = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(0, ADDR_CTRL, 0); chk(rd, CTRL_RST);
    bus(0, ADDR_CHGCFG, 0); chk(rd, CHGCFG_RST);
    bus(0, ADDR_COMP, 0); chk(rd, COMP_RST);
    bus(0, 8'h40, 0); chk(rd, 0);
    st = {CHGCFG_RST[6:0], CHGCFG_RST[11:8], CHGCFG_RST[18], CTRL_RST[9:8], CTRL_RST[10], 2'h0};
    chk({fcs, pre, rechg, boost_hot_threshold_select, boost_cold_threshold_select, hresp, sout}, st);
    // Each battery level: disable, then the enable toggle starts a fresh cycle
    for (n = 0; n < 3; n++) begin
      lvl <= n[1:0];
      bus(1, ADDR_CTRL, 32'he); repeat (6) @(posedge clk);
      bus(0, ADDR_STATUS, 0); chk({rd[1:0], oe}, 0);
      bus(1, ADDR_CTRL, 32'hf); repeat (6) @(posedge clk);
      bus(0, ADDR_STATUS, 0); chk({rd[1:0], cur, oe}, {(n == 2) ? 2'h2 : 2'h1, n[1:0], 1'b1});
    end
    dynamic_power_limit <= 1; full <= 1; repeat (20) @(posedge clk);
    bus(0, ADDR_STATUS, 0); chk(rd[1:0], 2'h2);
    dynamic_power_limit <= 0;
    @(negedge clk);
    while (int_n !== 1'b0) @(negedge clk);
    n = 0;
    while (int_n === 1'b0) begin @(negedge clk); n++; end
    chk(n, 8);
    @(posedge clk);
    bus(0, ADDR_STATUS, 0); chk({rd[1:0], oe, bsw}, {2'h3, 2'h0});
    full <= 0; repeat (6) @(posedge clk);
    bus(0, ADDR_STATUS, 0); chk(rd[1:0], 2'h2);
    bus(1, ADDR_CTRL, 32'hd); full <= 1; repeat (20) @(posedge clk);
    bus(0, ADDR_STATUS, 0); chk(rd[1:0], 2'h2);
    // Thermistor leaves the window while charging: suspend, record, resume
    ts <= 3'h3; repeat (6) @(posedge clk);
    bus(0, ADDR_FAULT, 0); chk({rd[6:0], chg}, {7'h6, 1'b0});
    bus(0, ADDR_FAULT, 0); chk(rd, 0);
    ts <= 3'h0; repeat (6) @(posedge clk);
    chk(chg, 1);
    // Boost with charging off: out of the boost window, then the wake button wakes it on release
    bus(1, ADDR_CTRL, 32'hc); boost <= 1'b1; repeat (6) @(posedge clk);
    chk({ben, bsw}, 2'h3);
    bts <= 1'b1; repeat (6) @(posedge clk);
    bus(0, ADDR_CTRL, 0); chk({rd[7], ben, bsw}, 3'h4);
    bus(0, ADDR_FAULT, 0); chk(rd, 32'h40);
    bts <= 1'b0; wake_n <= 1'b0; repeat (6) @(posedge clk);
    chk({ben, bsw}, 2'h0);
    wake_n <= 1'b1; repeat (6) @(posedge clk);
    chk({ben, bsw}, 2'h3);
    boost <= 1'b0;
    for (n = 0; n < 3; n++) begin
      st = rnd(); raw <= {st[7:0], rnd()};
      bus(1, ADDR_CTRL, 32'h4d); bus(0, ADDR_CTRL, 0); chk(rd[6], 1);
      @(negedge clk);
      while (conv === 1'b1) @(negedge clk);
      @(posedge clk);
      bus(0, ADDR_CTRL, 0); chk(rd[6], 0);
      bus(0, ADDR_MON0, 0); chk(rd, raw[31:0]);
      bus(0, ADDR_MON1, 0); chk(rd, raw[39:32]);
      st = rnd(); bus(1, ADDR_COMP, {8'h0, st[23:0]}); repeat (4) @(posedge clk);
      bus(0, ADDR_VREG, 0); chk({rd[8:0], vreg}, {2{exp_vreg(st, raw[39:32])}});
    end
    bus(1, ADDR_CTRL, 32'h2d); repeat (3) @(posedge clk);
    bus(0, ADDR_CTRL, 0); chk(rd[6], 1);
    bus(1, ADDR_CTRL, 32'hd); repeat (20) @(posedge clk);
    bus(0, ADDR_CTRL, 0); chk(rd[6], 0);
    give_verdict();
  end
endmodule : tb_top
